// ==== inc/fspg_map.svh ====
/*
 * Constants of the flash self-program guard: register offsets, field
 * positions, reset values, flash geometry and the arming window.
 * Assumes word addressing of a 32K-word flash with 128-word pages.
 */
`ifndef FSPG_MAP_SVH
`define FSPG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSPG_OFS_CTRL      8'h00
`define FSPG_OFS_STATUS    8'h04

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define FSPG_CTL_ENABLE    0
`define FSPG_CTL_ERASE     1
`define FSPG_CTL_WRITE     2
`define FSPG_CTL_LOCKSET   3
`define FSPG_CTL_BUSYCLR   4
`define FSPG_CTL_BUSY      6
`define FSPG_CTL_W         5
`define FSPG_ST_BLOCKED    8
`define FSPG_ST_HALT       9
`define FSPG_CTL_RST       5'h00
`define FSPG_LOCK_RST      4'hF

// ----------------------------------------------------------------
// Flash geometry, word addresses
// ----------------------------------------------------------------
`define FSPG_AW            15
`define FSPG_PAGE_LSB      7
`define FSPG_PW            8
`define FSPG_STALL_START   15'h7000
`define FSPG_BOOT_SZ0      15'h7000
`define FSPG_BOOT_SZ1      15'h7800
`define FSPG_BOOT_SZ2      15'h7C00
`define FSPG_BOOT_SZ3      15'h7E00

// ----------------------------------------------------------------
// Arming window after a control write, in clock cycles
// ----------------------------------------------------------------
`define FSPG_ARM_CYCLES    3'h4

`endif

// ==== inc/fspg_pkg.sv ====
/*
 * Types of the flash self-program guard.
 * Assumes nothing beyond the constants header.
 */
package fspg_pkg;

    // Operation state, Gray along idle -> rww -> stall
    typedef enum logic [1:0] {
        FS_IDLE  = 2'b00,
        FS_RWW   = 2'b01,
        FS_STALL = 2'b11
    } fspg_state_t;

endpackage : fspg_pkg

// ==== hdl/fspg_guard.sv ====
/*
 * Flash self-program guard: arms store-program-memory operations from
 * a control register, checks section and lock bits, starts page erase
 * and page write on the flash, stalls the core or blocks the
 * concurrent-read region, gates program-memory loads and interrupts.
 * Assumes a classic Wishbone master on sys_clk, a core that reports
 * its fetch address and a flash that pulses flashDone at the end.
 */
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "fspg_map.svh"

module fspg_guard
    import fspg_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    // Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Fuses and programmer
    input  wire logic [1:0]             bootSizeFuses,
    input  wire logic                   progLockWr,
    input  wire logic [3:0]             progLockData,
    input  wire logic                   chipErase,
    // Core side
    input  wire logic [`FSPG_AW-1:0]    cpuPc,
    input  wire logic                   spmExec,
    input  wire logic [`FSPG_AW-1:0]    spmTarget,
    input  wire logic [3:0]             spmLockData,
    input  wire logic [`FSPG_AW-1:0]    lpmAddr,
    input  wire logic                   intVecInBoot,
    output logic                        lpmAllow,
    output logic                        cpuHalt,
    output logic                        irqSuppress,
    output logic                        rwwReadBlock,
    // Flash side
    input  wire logic                   flashDone,
    output logic                        flashErase,
    output logic                        flashWrite,
    output logic                        flashBufLoad,
    output logic      [`FSPG_PW-1:0]    flashPage
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fspg_state_t              state_q, state_d;
    logic [`FSPG_CTL_W-1:0]   ctrl_q, ctrl_d;
    logic [2:0]               arm_q, arm_d;
    logic                     busy_q, busy_d;
    logic                     blocked_q, blocked_d;
    logic [3:0]               lock_q, lock_d;
    logic [`FSPG_PW-1:0]      page_q, page_d;
    logic                     erase_q, erase_d;
    logic                     write_q, write_d;
    logic                     bufLd_q, bufLd_d;
    logic                     ack_q, ack_d;
    logic [31:0]              rdat_q, rdat_d;

    // ------------------------------------------------------------
    // Section decode
    // ------------------------------------------------------------
    logic [`FSPG_AW-1:0] bootStart;
    logic                pcInBoot;
    logic                tgtInBoot;
    logic                lpmInBoot;
    logic                tgtInStall;
    logic                lpmInRww;

    // Boundary from fuses, all sizes inside stalling region
    always_comb begin
        unique case (bootSizeFuses)
            2'b00:   bootStart = `FSPG_BOOT_SZ0;
            2'b01:   bootStart = `FSPG_BOOT_SZ1;
            2'b10:   bootStart = `FSPG_BOOT_SZ2;
            2'b11:   bootStart = `FSPG_BOOT_SZ3;
        endcase
    end

    // Which section each address falls in
    assign pcInBoot   = (cpuPc >= bootStart);
    assign tgtInBoot  = (spmTarget >= bootStart);
    assign lpmInBoot  = (lpmAddr >= bootStart);
    assign tgtInStall = (spmTarget >= `FSPG_STALL_START);
    assign lpmInRww   = (lpmAddr < `FSPG_STALL_START);

    // ------------------------------------------------------------
    // Lock decode
    // ------------------------------------------------------------
    logic appUpper;
    logic appLower;
    logic bootUpper;
    logic bootLower;
    logic wrBlocked;
    logic rdBlocked;

    // Bits [1:0] application lock, [3:2] boot lock; 1 = unprogrammed
    assign appLower  = lock_q[0];
    assign appUpper  = lock_q[1];
    assign bootLower = lock_q[2];
    assign bootUpper = lock_q[3];

    // Write blocked when lower bit programmed (modes 2 and 3)
    always_comb begin
        if (tgtInBoot) begin
            wrBlocked = !bootLower;
        end else begin
            wrBlocked = !appLower;
        end
    end

    // Cross-section load blocked when upper bit programmed (modes 3, 4)
    always_comb begin
        if (pcInBoot && !lpmInBoot) begin
            rdBlocked = !appUpper;
        end else if (!pcInBoot && lpmInBoot) begin
            rdBlocked = !bootUpper;
        end else begin
            rdBlocked = 1'b0;
        end
    end

    // Load gate; general lock modes take no part here
    assign lpmAllow = !rdBlocked
                    && !(busy_q && lpmInRww)
                    && (state_q != FS_STALL);

    // Interrupt gate by vector placement
    always_comb begin
        irqSuppress = 1'b0;
        if (intVecInBoot && !pcInBoot && !appUpper) begin
            irqSuppress = 1'b1;
        end
        if (!intVecInBoot && pcInBoot && !bootUpper) begin
            irqSuppress = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic busReq;
    logic busWr;
    logic ctrlWr;
    logic spmOk;

    assign busReq = wb_cyc_i && wb_stb_i;
    // Write takes effect on the edge where ack is seen
    assign busWr  = busReq && wb_we_i && ack_q;
    assign ctrlWr = busWr && (wb_adr_i == `FSPG_OFS_CTRL) && wb_sel_i[0];

    // Accepted only from boot code inside the arming window
    assign spmOk  = spmExec && (arm_q != 3'h0)
                 && pcInBoot;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        ctrl_d    = ctrl_q;
        arm_d     = arm_q;
        busy_d    = busy_q;
        blocked_d = blocked_q;
        lock_d    = lock_q;
        page_d    = page_q;
        erase_d   = 1'b0;
        write_d   = 1'b0;
        bufLd_d   = 1'b0;
        ack_d     = busReq && !ack_q;
        rdat_d    = rdat_q;

        // Arming window countdown; expiry drops the request
        if (arm_q != 3'h0) begin
            arm_d = arm_q - 3'h1;
            if (arm_q == 3'h1 && !spmOk && state_q == FS_IDLE) begin
                ctrl_d = `FSPG_CTL_RST;
            end
        end

        // Control write arms the window while idle
        if (ctrlWr && state_q == FS_IDLE) begin
            ctrl_d    = wb_dat_i[`FSPG_CTL_W-1:0];
            blocked_d = 1'b0;
            if (wb_dat_i[`FSPG_CTL_ENABLE]) begin
                arm_d = `FSPG_ARM_CYCLES;
            end else begin
                arm_d = 3'h0;
            end
        end

        // Store-program-memory from an executing instruction
        if (spmOk && state_q == FS_IDLE) begin
            arm_d  = 3'h0;
            ctrl_d = `FSPG_CTL_RST;
            if (ctrl_q[`FSPG_CTL_ERASE] || ctrl_q[`FSPG_CTL_WRITE]) begin
                if (wrBlocked) begin
                    blocked_d = 1'b1;
                end else begin
                    // General write lock is not consulted
                    page_d  = spmTarget[`FSPG_AW-1:`FSPG_PAGE_LSB];
                    erase_d = ctrl_q[`FSPG_CTL_ERASE];
                    write_d = !ctrl_q[`FSPG_CTL_ERASE];
                    ctrl_d  = ctrl_q;     // stays visible until flashDone
                    busy_d  = 1'b1;
                    if (tgtInStall) begin
                        state_d = FS_STALL;
                    end else begin
                        state_d = FS_RWW;
                    end
                end
            end else if (ctrl_q[`FSPG_CTL_LOCKSET]) begin
                lock_d = lock_q & spmLockData;
            end else if (ctrl_q[`FSPG_CTL_BUSYCLR]) begin
                busy_d = 1'b0;
            end else begin
                bufLd_d = 1'b1;
            end
        end

        // Flash finished; flag stays until cleared
        if (state_q != FS_IDLE && flashDone) begin
            state_d = FS_IDLE;
            ctrl_d  = `FSPG_CTL_RST;
        end

        // Programmer may only program lock bits
        if (progLockWr) begin
            lock_d = lock_d & progLockData;
        end
        // Chip erase and reset are the only ways back to unprogrammed
        if (chipErase) begin
            lock_d = `FSPG_LOCK_RST;
        end

        // Read data latched on the request cycle
        if (busReq && !ack_q) begin
            rdat_d = 32'h0000_0000;
            unique case (wb_adr_i)
                `FSPG_OFS_CTRL: begin
                    rdat_d[`FSPG_CTL_W-1:0] = ctrl_q;
                    rdat_d[`FSPG_CTL_BUSY]  = busy_q;
                end
                `FSPG_OFS_STATUS: begin
                    rdat_d[3:0]              = lock_q;
                    rdat_d[5:4]              = bootSizeFuses;
                    rdat_d[`FSPG_ST_BLOCKED] = blocked_q;
                    rdat_d[`FSPG_ST_HALT]    = (state_q == FS_STALL);
                end
                default: begin
                    rdat_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= FS_IDLE;
            ctrl_q    <= `FSPG_CTL_RST;
            arm_q     <= 3'h0;
            busy_q    <= 1'b0;
            blocked_q <= 1'b0;
            lock_q    <= `FSPG_LOCK_RST;
            page_q    <= 8'h00;
            erase_q   <= 1'b0;
            write_q   <= 1'b0;
            bufLd_q   <= 1'b0;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0000_0000;
        end else begin
            state_q   <= state_d;
            ctrl_q    <= ctrl_d;
            arm_q     <= arm_d;
            busy_q    <= busy_d;
            blocked_q <= blocked_d;
            lock_q    <= lock_d;
            page_q    <= page_d;
            erase_q   <= erase_d;
            write_q   <= write_d;
            bufLd_q   <= bufLd_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdat_q;
    assign cpuHalt      = (state_q == FS_STALL);
    assign rwwReadBlock = busy_q;
    assign flashErase   = erase_q;
    assign flashWrite   = write_q;
    assign flashBufLoad = bufLd_q;
    assign flashPage    = page_q;

endmodule : fspg_guard

// ==== testbench/fspg_guard_assertions.sv ====
/*
 * Checker for the flash self-program guard: bus answer, arming window,
 * section checks, stall and region-busy timing.
 * Assumes binding to every fspg_guard; sees its ports only.
 */
`timescale 1ns/1ps
`include "fspg_map.svh"
module fspg_guard_chk (
    // Clock, reset and bus
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    // Core side
    input wire logic [1:0]  bootSizeFuses,
    input wire logic [14:0] cpuPc,
    input wire logic        spmExec,
    input wire logic [14:0] spmTarget,
    input wire logic        lpmAllow,
    input wire logic        cpuHalt,
    input wire logic        rwwReadBlock,
    // Flash side
    input wire logic        flashDone,
    input wire logic        flashErase,
    input wire logic        flashWrite,
    input wire logic [7:0]  flashPage
);
    logic [14:0] bootStart;
    logic        op;
    logic [2:0]  sinceArm_q;
    logic [2:0]  sinceArm_d;

    // Boot section start and operation start
    assign bootStart = bootSizeFuses[1] ? (bootSizeFuses[0] ? `FSPG_BOOT_SZ3 : `FSPG_BOOT_SZ2)
                                        : (bootSizeFuses[0] ? `FSPG_BOOT_SZ1 : `FSPG_BOOT_SZ0);
    assign op = flashErase | flashWrite;
    // Cycles since the last bus write, saturating
    assign sinceArm_d = (wb_ack_o && wb_we_i) ? 3'h0 : sinceArm_q + {2'h0, sinceArm_q != 3'h7};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            sinceArm_q <= 3'h7;
        else
            sinceArm_q <= sinceArm_d;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held too long");
    ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    app_spm_ignored_a: assert property (spmExec && cpuPc < bootStart |=> !op)
        else $error("store from application code started an operation");
    op_from_boot_a: assert property (op |-> $past(spmExec) && $past(cpuPc) >= bootStart)
        else $error("operation without a boot-section store");
    page_latched_a: assert property (op |-> flashPage == $past(spmTarget[14:7]))
        else $error("page not taken from target");
    halt_by_region_a: assert property (op |-> cpuHalt == ($past(spmTarget) >= `FSPG_STALL_START))
        else $error("stall choice wrong for target");
    halt_release_a: assert property (cpuHalt && flashDone |=> !cpuHalt)
        else $error("core still halted after done");
    halt_no_read_a: assert property (cpuHalt |-> !lpmAllow)
        else $error("load allowed while halted");
    busy_set_a: assert property (op |-> rwwReadBlock)
        else $error("region busy not set at start");
    busy_held_a: assert property (rwwReadBlock && !spmExec |=> rwwReadBlock)
        else $error("region busy dropped without clear");
    arm_window_a: assert property (op |-> sinceArm_q <= 3'h5)
        else $error("operation outside arming window");

    // Main scenarios
    stall_op_c: cover property (op && cpuHalt);
    rww_op_c: cover property (op && !cpuHalt);
    busy_clear_c: cover property ($fell(rwwReadBlock));
endmodule : fspg_guard_chk

bind fspg_guard fspg_guard_chk u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .bootSizeFuses(bootSizeFuses), .cpuPc(cpuPc),
    .spmExec(spmExec), .spmTarget(spmTarget), .lpmAllow(lpmAllow), .cpuHalt(cpuHalt),
    .rwwReadBlock(rwwReadBlock), .flashDone(flashDone), .flashErase(flashErase),
    .flashWrite(flashWrite), .flashPage(flashPage)
);

// ==== testbench/fspg_flash_model.sv ====
/*
 * Flash array model: answers each erase or write pulse with a
 * one-cycle done pulse after a bench-chosen number of cycles.
 * Assumes one operation at a time and a latency of at least 1.
 */
`timescale 1ns/1ps
module fspg_flash_model (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Guard side
    input wire logic       flashErase,
    input wire logic       flashWrite,
    output logic           flashDone,
    // Bench control
    input wire logic [3:0] latency
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // Busy countdown, done registered the cycle after it reaches 1
    assign cnt_d = (flashErase | flashWrite) ? latency : cnt_q - {3'h0, cnt_q != 4'h0};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q     <= 4'h0;
            flashDone <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            flashDone <= (cnt_q == 4'h1);
        end
    end
endmodule : fspg_flash_model

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for fspg_guard with the flash model on its flash side.
 * Assumes header, package, design, checker and model compiled first.
 */
`timescale 1ns/1ps
`include "fspg_map.svh"
module tb;
    logic        sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, progLockWr, chipErase;
    logic        spmExec, intVecInBoot, lpmAllow, cpuHalt, irqSuppress, rwwReadBlock, flashDone;
    logic        flashErase, flashWrite, flashBufLoad;
    logic [3:0]  wb_sel_i, progLockData, spmLockData, flashLat;
    logic [7:0]  wb_adr_i, flashPage;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0]  bootSizeFuses;
    logic [14:0] cpuPc, spmTarget, lpmAddr;
    int          errCount, nCompared;

    fspg_guard uut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bootSizeFuses(bootSizeFuses),
        .progLockWr(progLockWr), .progLockData(progLockData), .chipErase(chipErase),
        .cpuPc(cpuPc), .spmExec(spmExec), .spmTarget(spmTarget), .spmLockData(spmLockData),
        .lpmAddr(lpmAddr), .intVecInBoot(intVecInBoot), .lpmAllow(lpmAllow), .cpuHalt(cpuHalt),
        .irqSuppress(irqSuppress), .rwwReadBlock(rwwReadBlock), .flashDone(flashDone),
        .flashErase(flashErase), .flashWrite(flashWrite), .flashBufLoad(flashBufLoad),
        .flashPage(flashPage));
    fspg_flash_model u_flash (.sys_clk(sys_clk), .nrst(nrst), .flashErase(flashErase),
        .flashWrite(flashWrite), .flashDone(flashDone), .latency(flashLat));

    task automatic wrap_up();
        if (errCount == 0 && nCompared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tmo(input int n);
        if (n >= 40) begin
            errCount++;
            wrap_up();
        end
    endtask : tmo

    function automatic logic [14:0] bootBase(input logic [1:0] f);
        case (f)
            2'h0: return `FSPG_BOOT_SZ0;
            2'h1: return `FSPG_BOOT_SZ1;
            2'h2: return `FSPG_BOOT_SZ2;
            default: return `FSPG_BOOT_SZ3;
        endcase
    endfunction : bootBase

    // Single classic cycle; returns at the edge after the idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        tmo(n);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge sys_clk);
    endtask : wb

    task automatic setLocks(input logic [3:0] v);
        @(posedge sys_clk);
        chipErase <= 1'b1;
        @(posedge sys_clk);
        {chipErase, progLockWr, progLockData} <= {2'h1, v};
        @(posedge sys_clk);
        progLockWr <= 1'b0;
    endtask : setLocks

    // Arm with c, store k+2 edges after the write edge, follow to the end
    task automatic op(input logic [31:0] c, input logic [14:0] pc, input logic [14:0] t,
                      input int k, input logic ok);
        logic [31:0] q;
        int          n;
        wb(1'b1, 8'h00, c, q);
        repeat (k) @(posedge sys_clk);
        {cpuPc, lpmAddr, spmTarget, spmExec} <= {pc, pc, t, 1'b1};
        @(posedge sys_clk);
        spmExec <= 1'b0;
        #1;
        check("flashErase", 32'(flashErase), 32'(ok & c[1]));
        check("flashWrite", 32'(flashWrite), 32'(ok & c[2] & ~c[1]));
        check("flashBufLoad", 32'(flashBufLoad), 32'(ok && c[4:1] == 4'h0));
        if (ok && c[2:1] != 2'h0) begin
            check("flashPage", 32'(flashPage), 32'(t[14:7]));
            check("cpuHalt", 32'(cpuHalt), 32'(t >= `FSPG_STALL_START));
            check("lpmAllow", 32'(lpmAllow), 32'(t < `FSPG_STALL_START));
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (flashDone !== 1'b1 && n < 40);
            tmo(n);
            #1;
            check("haltEnd", 32'(cpuHalt), 32'h0);
            wb(1'b0, 8'h00, 32'h0, q);
            check("busyFlag", 32'(q[6]), 32'h1);
        end
    endtask : op

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        logic [31:0] q;
        logic [31:0] c;
        logic [1:0]  f;
        logic [14:0] pc;
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, progLockWr, chipErase, spmExec, intVecInBoot} = 8'h0;
        {wb_sel_i, wb_adr_i, wb_dat_i, progLockData, spmLockData, flashLat} = {4'hF, 48'h0, 4'h3};
        {bootSizeFuses, cpuPc, spmTarget, lpmAddr} = {2'h3, 45'h0};
        {errCount, nCompared} = {32'h0, 32'h0};
        void'($urandom(94094));
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        check("resetOut", 32'({cpuHalt, rwwReadBlock, flashErase}), 32'h0);
        wb(1'b0, 8'h04, 32'h0, q);
        check("statusReset", 32'(q[9:0]), 32'h0000_003F);
        wb(1'b0, 8'h10, 32'h0, q);
        check("unmapped", q, 32'h0000_0000);
        op(32'h0000_0003, 15'h0010, 15'h1000, 0, 1'b0);
        op(32'h0000_0003, 15'h7E10, 15'h1000, 3, 1'b0);
        op(32'h0000_0003, 15'h7E10, 15'h1000, 2, 1'b1);
        // Clear region busy so application-section loads are not blocked
        op(32'h0000_0011, 15'h7E10, 15'h0000, 0, 1'b1);
        check("busyClear", 32'(rwwReadBlock), 32'h0);
        // Load and interrupt gating for every lock pattern
        for (int i = 0; i < 16; i++) begin
            setLocks(4'(i));
            wb(1'b0, 8'h04, 32'h0, q);
            check("locks", 32'(q[3:0]), 32'(i));
            {cpuPc, lpmAddr, intVecInBoot} <= {15'h7E10, 15'h0200, 1'b1};
            #1;
            check("bootReadsApp", 32'(lpmAllow), 32'(i[1]));
            @(posedge sys_clk);
            {cpuPc, lpmAddr} <= {15'h0010, 15'h7F00};
            #1;
            check("appReadsBoot", 32'(lpmAllow), 32'(i[3]));
            check("irqInApp", 32'(irqSuppress), 32'(!i[1]));
            @(posedge sys_clk);
            {cpuPc, intVecInBoot} <= {15'h7E10, 1'b0};
            #1;
            check("sameSection", 32'(lpmAllow), 32'h1);
            check("irqInBoot", 32'(irqSuppress), 32'(!i[3]));
        end
        // Writes against every lock pattern
        for (int i = 0; i < 16; i++) begin
            setLocks(4'(i));
            op(32'h0000_0003, 15'h7E10, 15'h0100, 0, i[0]);
            op(32'h0000_0005, 15'h7E10, 15'h7F00, 0, i[2]);
            wb(1'b0, 8'h04, 32'h0, q);
            check("blocked", 32'(q[8]), 32'(!i[2]));
        end
        @(posedge sys_clk);
        spmLockData <= 4'h6;
        op(32'h0000_0009, 15'h7E10, 15'h0000, 0, 1'b1);
        wb(1'b0, 8'h04, 32'h0, q);
        check("spmLocks", 32'(q[3:0]), 32'h6);
        setLocks(4'hF);
        // Random fuses, targets, delays and flash latency
        for (int i = 0; i < 30; i++) begin
            f = 2'($urandom_range(3, 0));
            pc = bootBase(f) + 15'($urandom_range(15, 0));
            c = ($urandom_range(2, 0) == 0) ? 32'h0000_0001 : 32'h0000_0003 + 32'($urandom_range(2, 0) * 2);
            @(posedge sys_clk);
            {bootSizeFuses, flashLat} <= {f, 4'($urandom_range(9, 1))};
            op(c, pc, 15'($urandom_range(32767, 0)), $urandom_range(2, 0), 1'b1);
            op(32'h0000_0011, pc, 15'h0000, 0, 1'b1);
            check("busyClear", 32'(rwwReadBlock), 32'h0);
        end
        wrap_up();
    end
endmodule : tb
